// [verilog/pmc_defines.svh]
`ifndef PMC_DEFINES_SVH
`define PMC_DEFINES_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define PMC_OFF_SYS_SET 8'h00
`define PMC_OFF_SYS_CLR 8'h04
`define PMC_OFF_SYS_STATE 8'h08
`define PMC_OFF_PER_SET 8'h10
`define PMC_OFF_PER_CLR 8'h14
`define PMC_OFF_PER_STATE 8'h18
`define PMC_OFF_PLL_SETUP 8'h2C
`define PMC_OFF_MASTER 8'h30
`define PMC_OFF_PROG0 8'h40
`define PMC_OFF_PROG1 8'h44
`define PMC_OFF_PROG2 8'h48
`define PMC_OFF_STATUS 8'h68

// ----------------------------------------
// field positions
// ----------------------------------------
`define PMC_SYS_CPU_BIT 0
`define PMC_SYS_PROG_LSB 8
`define PMC_PLL_DIV_LSB 0
`define PMC_PLL_CNT_LSB 8
`define PMC_PLL_MUL_LSB 16
`define PMC_MCK_SRC_LSB 0
`define PMC_MCK_RATIO_LSB 2
`define PMC_ST_LOCK_BIT 2
`define PMC_ST_MDONE_BIT 3
`define PMC_ST_PROG_LSB 8

// ----------------------------------------
// reset values and sizes
// ----------------------------------------
`define PMC_DIV_RESET 8'h00
`define PMC_MUL_RESET 11'h000
`define PMC_CNT_RESET 6'h00
`define PMC_NUM_PERIPH 16
`define PMC_NUM_PROG 3
`define PMC_RESP_OKAY 2'b00
`define PMC_RESP_SLVERR 2'b10

`endif

// [verilog/pmc_pkg.sv]
package pmc_pkg;

  // ----------------------------------------
  // clock sources and configuration types
  // ----------------------------------------
  typedef enum logic [1:0] {
    PMC_SRC_SLOW,
    PMC_SRC_MAIN,
    PMC_SRC_PLL,
    PMC_SRC_RSVD
  } pmc_src_t;

  typedef struct packed {
    logic [10:0] pll_gain_factor;
    logic [5:0] pll_settle_counter;
    logic [7:0] div;
  } pmc_pll_cfg_t;

  typedef struct packed {
    pmc_src_t master_source_select;
    logic [2:0] master_ratio_field;
  } pmc_sel_t;

endpackage : pmc_pkg

// [verilog/pmc_clock_ctrl.sv]
// Chosen here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "pmc_defines.svh"
// Contract
// - slow rc clock is the only permanent clock; others may stop
// - generator provides slow, main oscillator and pll output clocks
// - pll input divider accepts 1 to 255 in steps of one
// - divider zero holds divider and pll output low
// - divider field resets to zero, pll input stopped
// - pll frequency is source times (gain plus one) over divider
// - gain zero disables pll; nonzero re-enables it
// - settled flag clears on pll re-enable or parameter rewrite
// - settle count loaded, decremented per slow clock, sets flag at zero
// - master source chosen among generator outputs; slow drives whole device
// - master prescaler divides by power of two, 1 to 64
// - master register write clears done flag until new clock established
// - master clock feeds peripherals, memory controller, permanent modules
// - processor clock off in idle; set write enables, clear write disables
// - processor clock state readable in system clock state register
// - each peripheral gets own independently gated master clock copy
// - each programmable output picks a generator clock onto its pin
// - processor clock on after reset, re-enabled by interrupt or reset
// - processor clock stops only after current instruction completes
module pmc_clock_ctrl
  import pmc_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic slow_rc_clock,
  input wire logic main_oscillator_clock,
  input wire logic cpu_instr_done,
  input wire logic irq_wake,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic pll_output_clock,
  output logic master_clock,
  output logic processor_clock,
  output logic [`PMC_NUM_PERIPH-1:0] periph_clock,
  output logic [`PMC_NUM_PROG-1:0] programmable_clock_outputs
);

  // ----------------------------------------
  // pin synchronisers and source ticks
  // ----------------------------------------
  logic [2:0] slow_sync_reg;
  logic [2:0] main_sync_reg;
  wire slow_tick = slow_sync_reg[1] & ~slow_sync_reg[2];
  wire main_tick = main_sync_reg[1] & ~main_sync_reg[2];

  always_ff @(posedge mclk) begin
    if (reset) begin
      slow_sync_reg <= 3'h0;
      main_sync_reg <= 3'h0;
    end else begin
      slow_sync_reg <= {slow_sync_reg[1:0], slow_rc_clock};
      main_sync_reg <= {main_sync_reg[1:0], main_oscillator_clock};
    end
  end

  // ----------------------------------------
  // axi4-lite slave
  // ----------------------------------------
  pmc_pll_cfg_t pll_cfg_reg;
  pmc_sel_t mck_sel_reg;
  pmc_sel_t mck_cur_reg;
  pmc_sel_t prog_sel_reg [`PMC_NUM_PROG];
  logic cpu_en_reg;
  logic cpu_run_reg;
  logic [`PMC_NUM_PROG-1:0] prog_en_reg;
  logic [`PMC_NUM_PROG-1:0] prog_rdy_reg;
  logic [`PMC_NUM_PERIPH-1:0] per_en_reg;
  logic lock_reg;
  logic counting_reg;
  logic [5:0] lock_cnt_reg;
  logic mdone_reg;
  logic mpend_reg;
  logic [31:0] rdata_next;
  logic rhit;
  logic [4:0] prog_sel_rd [`PMC_NUM_PROG];

  // writes only with full word strobes; a partial word is ignored
  wire wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  wire wr_full = (s_axi_wstrb == 4'hF);
  wire [7:0] wa = s_axi_awaddr;
  wire [31:0] wd = s_axi_wdata;
  wire wr_sys_set = wr_go & wr_full & (wa == `PMC_OFF_SYS_SET);
  wire wr_sys_clr = wr_go & wr_full & (wa == `PMC_OFF_SYS_CLR);
  wire wr_per_set = wr_go & wr_full & (wa == `PMC_OFF_PER_SET);
  wire wr_per_clr = wr_go & wr_full & (wa == `PMC_OFF_PER_CLR);
  wire wr_pll = wr_go & wr_full & (wa == `PMC_OFF_PLL_SETUP);
  wire wr_mck = wr_go & wr_full & (wa == `PMC_OFF_MASTER);
  wire [2:0] wr_prog;
  assign wr_prog[0] = wr_go & wr_full & (wa == `PMC_OFF_PROG0);
  assign wr_prog[1] = wr_go & wr_full & (wa == `PMC_OFF_PROG1);
  assign wr_prog[2] = wr_go & wr_full & (wa == `PMC_OFF_PROG2);
  wire wr_hit = wr_sys_set | wr_sys_clr | wr_per_set | wr_per_clr | wr_pll | wr_mck
    | (|wr_prog);
  wire rd_go = s_axi_arvalid & ~s_axi_rvalid;

  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = rd_go;

  always_ff @(posedge mclk) begin
    if (reset) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PMC_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? `PMC_RESP_OKAY : `PMC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  wire [31:0] sys_state = {21'h0, prog_en_reg, 7'h0, cpu_run_reg};
  wire [31:0] status_word = {21'h0, prog_rdy_reg, 4'h0, mdone_reg, lock_reg, 2'h0};
  // readback in write layout: source in the low bits, ratio above
  wire [4:0] mck_sel_rd = {mck_sel_reg.master_ratio_field, mck_sel_reg.master_source_select};

  always_comb begin
    rdata_next = 32'h0000_0000;
    rhit = 1'b1;
    unique case (s_axi_araddr)
      `PMC_OFF_SYS_STATE: rdata_next = sys_state;
      `PMC_OFF_PER_STATE: rdata_next = {16'h0000, per_en_reg};
      `PMC_OFF_PLL_SETUP: rdata_next = {5'h00, pll_cfg_reg.pll_gain_factor, 2'h0,
        pll_cfg_reg.pll_settle_counter, pll_cfg_reg.div};
      `PMC_OFF_MASTER: rdata_next = {27'h0, mck_sel_rd};
      `PMC_OFF_PROG0: rdata_next = {27'h0, prog_sel_rd[0]};
      `PMC_OFF_PROG1: rdata_next = {27'h0, prog_sel_rd[1]};
      `PMC_OFF_PROG2: rdata_next = {27'h0, prog_sel_rd[2]};
      `PMC_OFF_STATUS: rdata_next = status_word;
      `PMC_OFF_SYS_SET, `PMC_OFF_SYS_CLR, `PMC_OFF_PER_SET, `PMC_OFF_PER_CLR:
        rdata_next = 32'h0000_0000;
      default: rhit = 1'b0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `PMC_RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdata_next;
      s_axi_rresp <= rhit ? `PMC_RESP_OKAY : `PMC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // pll: divider, multiplier, settle counter
  // ----------------------------------------
  // pll runs only with divider and gain nonzero
  wire pll_on = (pll_cfg_reg.div != 8'h00) & (pll_cfg_reg.pll_gain_factor != 11'h000);
  logic [19:0] pll_acc_reg;
  logic pll_tick_reg;
  // rate is capped at one tick per mclk cycle
  // accumulate gain plus one per main tick, spend divider per output tick
  wire pll_emit = pll_on & (pll_acc_reg >= {12'h000, pll_cfg_reg.div});
  // saturate near the top so a capped rate never wraps the accumulator
  wire [19:0] pll_add = (main_tick & ~pll_acc_reg[19])
    ? {8'h00, 1'b0, pll_cfg_reg.pll_gain_factor} + 20'h0_0001 : 20'h0_0000;
  wire [19:0] pll_sub = pll_emit ? {12'h000, pll_cfg_reg.div} : 20'h0_0000;

  always_ff @(posedge mclk) begin
    if (reset || !pll_on) begin
      pll_acc_reg <= 20'h0_0000;
      pll_tick_reg <= 1'b0;
      pll_output_clock <= 1'b0;
    end else begin
      pll_acc_reg <= pll_acc_reg + pll_add - pll_sub;
      pll_tick_reg <= pll_emit;
      if (pll_emit) begin
        pll_output_clock <= ~pll_output_clock;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      pll_cfg_reg <= '{`PMC_MUL_RESET, `PMC_CNT_RESET, `PMC_DIV_RESET};
      lock_reg <= 1'b0;
      counting_reg <= 1'b0;
      lock_cnt_reg <= 6'h00;
    end else if (wr_pll) begin
      pll_cfg_reg.div <= wd[`PMC_PLL_DIV_LSB +: 8];
      pll_cfg_reg.pll_settle_counter <= wd[`PMC_PLL_CNT_LSB +: 6];
      pll_cfg_reg.pll_gain_factor <= wd[`PMC_PLL_MUL_LSB +: 11];
      lock_reg <= 1'b0;
      counting_reg <= 1'b1;
      lock_cnt_reg <= wd[`PMC_PLL_CNT_LSB +: 6];
    end else if (counting_reg && slow_tick) begin
      // count down on slow clock, flag at zero
      if (lock_cnt_reg == 6'h00) begin
        lock_reg <= 1'b1;
        counting_reg <= 1'b0;
      end else begin
        lock_cnt_reg <= lock_cnt_reg - 6'h01;
      end
    end
  end

  // ----------------------------------------
  // master clock selector and prescaler
  // ----------------------------------------
  // source ticks from the three generator outputs
  wire [3:0] src_ticks = {1'b0, pll_tick_reg, main_tick, slow_tick};
  wire mck_src_tick = src_ticks[mck_cur_reg.master_source_select];
  logic [5:0] mck_cnt_reg;
  logic mck_tick_reg;
  // ratio mask 2**field - 1, field above 6 treated as 6
  wire [2:0] mck_ratio = (mck_cur_reg.master_ratio_field > 3'd6) ? 3'd6
    : mck_cur_reg.master_ratio_field;
  wire [5:0] mck_mask = 6'(7'h01 << mck_ratio) - 6'h01;
  wire mck_wrap = mck_src_tick & (mck_cnt_reg == mck_mask);
  // switch only on a period boundary, or when the old source is the pll and the pll is off
  wire mck_src_dead = (mck_cur_reg.master_source_select == PMC_SRC_PLL) & ~pll_on;
  wire mck_apply = mpend_reg & ~wr_mck & (mck_wrap | mck_src_dead);

  always_ff @(posedge mclk) begin
    if (reset) begin
      mck_sel_reg <= '{PMC_SRC_SLOW, 3'h0};
      mck_cur_reg <= '{PMC_SRC_SLOW, 3'h0};
      mck_cnt_reg <= 6'h00;
      mck_tick_reg <= 1'b0;
      master_clock <= 1'b0;
      mpend_reg <= 1'b0;
      mdone_reg <= 1'b1;
    end else begin
      mck_tick_reg <= mck_wrap;
      if (mck_wrap) begin
        master_clock <= ~master_clock;
      end
      if (mck_apply) begin
        mck_cur_reg <= mck_sel_reg;
        mck_cnt_reg <= 6'h00;
      end else if (mck_wrap) begin
        mck_cnt_reg <= 6'h00;
      end else if (mck_src_tick) begin
        mck_cnt_reg <= mck_cnt_reg + 6'h01;
      end
      // write clears done, set when the new clock takes over
      if (wr_mck) begin
        mck_sel_reg <= '{pmc_src_t'(wd[`PMC_MCK_SRC_LSB +: 2]), wd[`PMC_MCK_RATIO_LSB +: 3]};
        mpend_reg <= 1'b1;
        mdone_reg <= 1'b0;
      end else if (mck_apply) begin
        mpend_reg <= 1'b0;
        mdone_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // processor and peripheral clock gating
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      cpu_en_reg <= 1'b1;
      cpu_run_reg <= 1'b1;
      per_en_reg <= '0;
      prog_en_reg <= '0;
    end else begin
      // set write or interrupt wins over clear write
      if ((wr_sys_set && wd[`PMC_SYS_CPU_BIT]) || irq_wake) begin
        cpu_en_reg <= 1'b1;
      end else if (wr_sys_clr && wd[`PMC_SYS_CPU_BIT]) begin
        cpu_en_reg <= 1'b0;
      end
      // stop only at an instruction boundary
      if (cpu_en_reg || cpu_instr_done) begin
        cpu_run_reg <= cpu_en_reg;
      end
      per_en_reg <= (per_en_reg & ~({`PMC_NUM_PERIPH{wr_per_clr}} & wd[15:0]))
        | ({`PMC_NUM_PERIPH{wr_per_set}} & wd[15:0]);
      prog_en_reg <= (prog_en_reg & ~({3{wr_sys_clr}} & wd[`PMC_SYS_PROG_LSB +: 3]))
        | ({3{wr_sys_set}} & wd[`PMC_SYS_PROG_LSB +: 3]);
    end
  end

  // master clock level runs to memory controller and permanent modules
  // processor copy gated by run state
  assign processor_clock = master_clock & cpu_run_reg;

  genvar gi;
  generate
    for (gi = 0; gi < `PMC_NUM_PERIPH; gi++) begin : g_periph
      assign periph_clock[gi] = master_clock & per_en_reg[gi];
    end
  endgenerate

  // ----------------------------------------
  // programmable clock outputs
  // ----------------------------------------
  // no glitch protection here: software must disable before reconfiguring
  generate
    for (gi = 0; gi < `PMC_NUM_PROG; gi++) begin : g_prog
      logic [5:0] cnt_reg;
      wire src_tick = src_ticks[prog_sel_reg[gi].master_source_select];
      wire [2:0] ratio = (prog_sel_reg[gi].master_ratio_field > 3'd6) ? 3'd6
        : prog_sel_reg[gi].master_ratio_field;
      wire [5:0] mask = 6'(7'h01 << ratio) - 6'h01;
      wire wrap = src_tick & (cnt_reg == mask);
      assign prog_sel_rd[gi] = {prog_sel_reg[gi].master_ratio_field,
        prog_sel_reg[gi].master_source_select};
      always_ff @(posedge mclk) begin
        if (reset) begin
          prog_sel_reg[gi] <= '{PMC_SRC_SLOW, 3'h0};
          cnt_reg <= 6'h00;
          prog_rdy_reg[gi] <= 1'b0;
          programmable_clock_outputs[gi] <= 1'b0;
        end else if (wr_prog[gi]) begin
          prog_sel_reg[gi] <= '{pmc_src_t'(wd[1:0]), wd[4:2]};
          cnt_reg <= 6'h00;
          prog_rdy_reg[gi] <= 1'b0;
        end else begin
          cnt_reg <= wrap ? 6'h00 : (src_tick ? cnt_reg + 6'h01 : cnt_reg);
          if (wrap) begin
            prog_rdy_reg[gi] <= 1'b1;
          end
          // selected source onto its pin, parked low when disabled
          if (!prog_en_reg[gi]) begin
            programmable_clock_outputs[gi] <= 1'b0;
          end else if (wrap) begin
            programmable_clock_outputs[gi] <= ~programmable_clock_outputs[gi];
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence s_pll_write;
    wr_pll;
  endsequence
  sequence s_lock_clear;
    ##1 !lock_reg;
  endsequence

  a_lock_clears_write: assert property (@(posedge mclk) disable iff (reset)
    s_pll_write |-> s_lock_clear) else $error("settle flag not cleared by pll write");
  a_pll_zero_div: assert property (@(posedge mclk) disable iff (reset)
    (pll_cfg_reg.div == 8'h00) |=> !pll_output_clock) else $error("pll output not low");
  a_pll_zero_gain: assert property (@(posedge mclk) disable iff (reset)
    (pll_cfg_reg.pll_gain_factor == 11'h000) |=> !pll_tick_reg) else $error("pll not off");
  a_lock_sets_zero: assert property (@(posedge mclk) disable iff (reset)
    counting_reg && slow_tick && lock_cnt_reg == 6'h00 && !wr_pll |=> lock_reg && !counting_reg)
    else $error("settle flag not set at zero");
  a_lock_early: assert property (@(posedge mclk) disable iff (reset)
    $rose(lock_reg) |-> $past(lock_cnt_reg) == 6'h00) else $error("settle flag set early");
  a_mck_done_clear: assert property (@(posedge mclk) disable iff (reset)
    wr_mck |=> !mdone_reg && mpend_reg) else $error("switch done not cleared");
  a_mck_glitch_free: assert property (@(posedge mclk) disable iff (reset)
    $changed(mck_cur_reg) |-> $past(mck_wrap) || $past(mck_src_dead))
    else $error("master switched mid period");
  a_cpu_wake: assert property (@(posedge mclk) disable iff (reset)
    irq_wake |=> cpu_en_reg ##1 cpu_run_reg) else $error("processor clock not woken");
  a_cpu_idle_stop: assert property (@(posedge mclk) disable iff (reset)
    $fell(cpu_run_reg) |-> $past(cpu_instr_done)) else $error("processor stopped mid instr");
  a_periph_gate: assert property (@(posedge mclk) disable iff (reset)
    !per_en_reg[0] |-> !periph_clock[0]) else $error("peripheral clock leaks");

endmodule : pmc_clock_ctrl

// [verification/test_pll_and_master_clock_control.sv]
`timescale 1ns/10ps
`include "pmc_defines.svh"
module test_pll_and_master_clock_control
  import pmc_pkg::*;
();
  `define CHECK(nm, ex, gt) begin comparisons++; if ((ex) !== (gt)) begin failures++; \
    $display("wrong value %s expected %0h seen %0h", nm, ex, gt); end end
  logic mclk = 0, reset = 1, slow_rc_clock = 0, main_oscillator_clock = 0;
  logic cpu_instr_done = 0, irq_wake = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0, rdata, d;
  logic [3:0] wstrb = 0;
  logic awready, wready, bvalid, arready, rvalid, pll_output_clock, master_clock;
  logic processor_clock;
  logic [1:0] bresp, rresp, r;
  logic [15:0] periph_clock;
  logic [2:0] programmable_clock_outputs;
  logic [4:0] div_cnt = 0;
  int failures = 0, comparisons = 0, cyc = 0, t_mark, n, dt;
  logic [31:0] mtab [4] = '{32'h0000_0004, 32'h0000_0005, 32'h0000_0001, 32'h0000_0002};
  int ttab [4] = '{12, 100, 200, 300};

  // ----------------------------------------
  // clocks and design
  // ----------------------------------------
  always #2.5 mclk = ~mclk;
  // main tick every 4 cycles, slow tick every 32
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    div_cnt <= div_cnt + 5'h01;
    main_oscillator_clock <= div_cnt[1];
    slow_rc_clock <= div_cnt[4];
  end
  pmc_clock_ctrl dut_u (.mclk(mclk), .reset(reset), .slow_rc_clock(slow_rc_clock),
    .main_oscillator_clock(main_oscillator_clock), .cpu_instr_done(cpu_instr_done),
    .irq_wake(irq_wake), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pll_output_clock(pll_output_clock), .master_clock(master_clock),
    .processor_clock(processor_clock), .periph_clock(periph_clock),
    .programmable_clock_outputs(programmable_clock_outputs));

  // ----------------------------------------
  // bus tasks and helpers
  // ----------------------------------------
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic aw_ok, w_ok;
    int t;
    aw_ok = 0;
    w_ok = 0;
    t = 0;
    @(posedge mclk);
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hF;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    rs = 2'b11;
    while (t < 1000) begin
      @(posedge mclk);
      t++;
      if (awvalid && awready) begin aw_ok = 1; awvalid <= 0; end
      if (wvalid && wready) begin w_ok = 1; wvalid <= 0; end
      if (aw_ok && w_ok && bvalid) begin rs = bresp; bready <= 0; break; end
    end
    if (t >= 1000) failures++;
    t_mark = cyc;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    int t;
    t = 0;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    v = 32'hFFFF_FFFF;
    rs = 2'b11;
    while (t < 1000) begin
      @(posedge mclk);
      t++;
      if (arvalid && arready) arvalid <= 0;
      if (!arvalid && rvalid) begin v = rdata; rs = rresp; rready <= 0; break; end
    end
    if (t >= 1000) failures++;
  endtask : axi_rd

  function automatic logic pick(input int w);
    if (w == 0) return pll_output_clock;
    if (w == 1) return master_clock;
    if (w == 2) return processor_clock;
    if (w < 30) return periph_clock[w - 10];
    return programmable_clock_outputs[w - 30];
  endfunction : pick

  // edge count over a window, sampled after the edge settles
  task automatic toggles(input int w, input int len, output int cnt);
    logic last;
    cnt = 0;
    @(posedge mclk);
    #1;
    last = pick(w);
    repeat (len) begin
      @(posedge mclk);
      #1;
      if (pick(w) !== last) cnt++;
      last = pick(w);
    end
  endtask : toggles

  task automatic near(input string nm, input int got, input int ex, input int tol);
    `CHECK(nm, ex, ((got >= ex - tol) && (got <= ex + tol)) ? ex : got)
  endtask : near

  // polls a status bit; dt counts from the last write
  task automatic wait_flag(input int b, output int span);
    logic [31:0] v;
    logic [1:0] rs;
    v = 0;
    repeat (800) begin
      axi_rd(`PMC_OFF_STATUS, v, rs);
      if (v[b] === 1'b1) break;
    end
    span = cyc - t_mark;
    `CHECK("status flag", 1'b1, v[b])
  endtask : wait_flag

  task automatic close_out;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out

  initial begin
    #300000;
    failures++;
    close_out();
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge mclk);
    reset <= 0;
    axi_rd(`PMC_OFF_SYS_STATE, d, r); `CHECK("processor run", 32'h1, d)
    axi_rd(`PMC_OFF_STATUS, d, r); `CHECK("status reset", 32'h8, d & 32'h0C)
    axi_rd(`PMC_OFF_PLL_SETUP, d, r); `CHECK("pll setup reset", 32'h0, d)
    toggles(0, 400, n); near("pll stopped", n, 0, 0);
    toggles(1, 800, n); near("master on slow", n, 25, 3);
    axi_rd(8'h7C, d, r); `CHECK("unmapped resp", `PMC_RESP_SLVERR, r)
    `CHECK("unmapped data", 32'h0, d)
    axi_wr(`PMC_OFF_SYS_STATE, 32'h1, r); `CHECK("ro write", `PMC_RESP_SLVERR, r)
    // pll settle count and rate
    axi_wr(`PMC_OFF_PLL_SETUP, 32'h0001_0301, r);
    axi_rd(`PMC_OFF_STATUS, d, r); `CHECK("settle cleared", 1'b0, d[2])
    wait_flag(2, dt); near("settle span", dt, 120, 30);
    toggles(0, 400, n); near("pll rate", n, 200, 3);
    axi_wr(`PMC_OFF_PLL_SETUP, 32'h0001_0301, r);
    axi_rd(`PMC_OFF_STATUS, d, r); `CHECK("settle recleared", 1'b0, d[2])
    repeat (60) @(posedge mclk);
    axi_wr(`PMC_OFF_PLL_SETUP, 32'h0001_0301, r);
    wait_flag(2, dt); near("settle restart", dt, 120, 30);
    axi_wr(`PMC_OFF_PLL_SETUP, 32'h0000_0301, r);
    toggles(0, 400, n); near("pll gain zero", n, 0, 0);
    axi_wr(`PMC_OFF_PLL_SETUP, 32'h0003_0300, r);
    toggles(0, 400, n); near("pll div zero", n, 0, 0);
    axi_wr(`PMC_OFF_PLL_SETUP, 32'h00FE_03FF, r);
    toggles(0, 400, n); near("pll div max", n, 100, 3);
    axi_wr(`PMC_OFF_PLL_SETUP, 32'h0002_0302, r);
    toggles(0, 400, n); near("pll ratio", n, 150, 3);
    // master source and prescaler table
    for (int i = 0; i < 4; i++) begin
      axi_wr(`PMC_OFF_MASTER, mtab[i], r);
      axi_rd(`PMC_OFF_STATUS, d, r);
      if (i == 1) `CHECK("switch pending", 1'b0, d[3])
      wait_flag(3, dt);
      toggles(1, 800, n); near("master rate", n, ttab[i], 3);
    end
    axi_wr(`PMC_OFF_MASTER, 32'h0000_0001, r);
    wait_flag(3, dt);
    axi_rd(`PMC_OFF_MASTER, d, r); `CHECK("master readback", 32'h0000_0001, d)
    // processor idle and wake
    axi_wr(`PMC_OFF_SYS_CLR, 32'h1, r);
    toggles(2, 200, n); near("cpu mid instr", n, 50, 3);
    cpu_instr_done <= 1;
    repeat (4) @(posedge mclk);
    toggles(2, 200, n); near("cpu idle", n, 0, 0);
    toggles(1, 200, n); near("master in idle", n, 50, 3);
    axi_rd(`PMC_OFF_SYS_STATE, d, r); `CHECK("cpu state off", 1'b0, d[0])
    irq_wake <= 1;
    @(posedge mclk);
    irq_wake <= 0;
    toggles(2, 200, n); near("cpu woken", n, 50, 3);
    axi_rd(`PMC_OFF_SYS_STATE, d, r); `CHECK("cpu state on", 1'b1, d[0])
    axi_wr(`PMC_OFF_SYS_CLR, 32'h1, r);
    axi_wr(`PMC_OFF_SYS_SET, 32'h1, r);
    toggles(2, 200, n); near("cpu set", n, 50, 3);
    // peripheral gates
    axi_wr(`PMC_OFF_PER_SET, 32'h0000_0005, r);
    for (int i = 0; i < 3; i++) begin
      toggles(10 + i, 200, n); near("periph gate", n, (i == 1) ? 0 : 50, 3);
    end
    axi_wr(`PMC_OFF_PER_CLR, 32'h0000_0001, r);
    axi_rd(`PMC_OFF_PER_STATE, d, r); `CHECK("periph state", 32'h0000_0004, d)
    // programmable output
    axi_wr(`PMC_OFF_PROG0, 32'h0000_0001, r);
    axi_wr(`PMC_OFF_SYS_SET, 32'h0000_0100, r);
    toggles(30, 400, n); near("prog0 main", n, 100, 3);
    toggles(31, 400, n); near("prog1 off", n, 0, 0);
    axi_rd(`PMC_OFF_PROG0, d, r); `CHECK("prog0 readback", 32'h0000_0001, d)
    axi_rd(`PMC_OFF_SYS_STATE, d, r); `CHECK("sys state", 32'h0000_0101, d)
    close_out();
  end
endmodule : test_pll_and_master_clock_control
